/* File: pbsp_defines.svh */
// Constants for the pattern buffer signalling port.
`ifndef PBSP_DEFINES_SVH
`define PBSP_DEFINES_SVH
`define PBSP_ADDR_STRAP_LOW 7'h1b
`define PBSP_ADDR_STRAP_HIGH 7'h1d
`define PBSP_IDX_RESET 2'h0
`define PBSP_IDX_STEP 2'h1
`define PBSP_SYNC_RESET 3'h0
`define PBSP_SYNC_DEPTH 2'h3
`define PBSP_FILL_RESET 2'h0
`define PBSP_FILL_STEP 2'h1
`endif

/* File: pbsp_pkg.sv */
// Types shared by the pattern buffer signalling port.
package pbsp_pkg;
  typedef enum logic [1:0] {
    PBSP_ST_STRAP = 2'b00,
    PBSP_ST_LOAD = 2'b01,
    PBSP_ST_IDLE = 2'b10,
    PBSP_ST_RUN = 2'b11
  } pbsp_state_t;
  typedef struct packed {
    logic invert;
    logic [1:0] index;
    logic advance;
    logic trigger;
  } pbsp_pins_t;
  typedef struct packed {
    logic invert;
    logic advance;
    logic trigger;
  } pbsp_req_t;
endpackage

/* File: pbsp_port.sv */
// Pattern buffer signalling port toward a companion FPGA.
`timescale 1ns/1ps
`include "pbsp_defines.svh"
module pbsp_port (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic config_loaded_i,
  input wire logic buffer_ctrl_en_i,
  input wire pbsp_pkg::pbsp_req_t req_i,
  input wire logic addr_strap_pin_i,
  output pbsp_pkg::pbsp_pins_t pins_o,
  output logic buffer_index_msb_oe_o,
  output logic pins_oe_o,
  output logic [6:0] target_addr_o,
  output logic addr_valid_o
);
  import pbsp_pkg::*;

  pbsp_state_t state;
  logic [2:0] strap_sync;
  logic [1:0] index;
  logic [1:0] next_index;
  logic [1:0] strap_fill;
  logic strap_full;
  logic strap_steady;

  // Pin input passes three flops; the level is trusted once stages two and three agree.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      strap_sync <= `PBSP_SYNC_RESET;
    end else if (clk_en_i) begin
      strap_sync <= {strap_sync[1:0], addr_strap_pin_i};
    end
  end

  // The strap is trusted only after all three stages hold real pin samples, not reset zeros.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      strap_fill <= `PBSP_FILL_RESET;
    end else if (clk_en_i && !strap_full) begin
      strap_fill <= strap_fill + `PBSP_FILL_STEP;
    end
  end

  assign strap_full = (strap_fill == `PBSP_SYNC_DEPTH);
  assign strap_steady = (strap_sync[2] == strap_sync[1]);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state <= PBSP_ST_STRAP;
    end else if (clk_en_i) begin
      unique case (state)
        PBSP_ST_STRAP: begin
          // Leave only once the address has been taken from a settled strap.
          if (addr_valid_o) begin
            state <= PBSP_ST_LOAD;
          end
        end
        PBSP_ST_LOAD: begin
          if (config_loaded_i) begin
            state <= PBSP_ST_IDLE;
          end
        end
        PBSP_ST_IDLE: begin
          if (buffer_ctrl_en_i) begin
            state <= PBSP_ST_RUN;
          end
        end
        PBSP_ST_RUN: begin
          if (!buffer_ctrl_en_i) begin
            state <= PBSP_ST_IDLE;
          end
        end
      endcase
    end
  end

  // Address is caught once, after reset release, from the settled strap.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      target_addr_o <= `PBSP_ADDR_STRAP_LOW;
      addr_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      // A strap that keeps moving is never taken; the port then waits in the strap state.
      if (state == PBSP_ST_STRAP && !addr_valid_o && strap_full && strap_steady) begin
        addr_valid_o <= 1'b1;
        target_addr_o <= strap_sync[2] ? `PBSP_ADDR_STRAP_HIGH : `PBSP_ADDR_STRAP_LOW;
      end
    end
  end

  // One adder feeds both the counter and the pin so the strobe and the index cannot disagree.
  always_comb begin
    next_index = index + `PBSP_IDX_STEP;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      index <= `PBSP_IDX_RESET;
    end else if (clk_en_i && state == PBSP_ST_RUN && req_i.advance) begin
      index <= next_index;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pins_o <= '0;
    end else if (clk_en_i) begin
      if (state == PBSP_ST_RUN) begin
        pins_o.invert <= req_i.invert;
        pins_o.index <= req_i.advance ? next_index : index;
        pins_o.advance <= req_i.advance;
        pins_o.trigger <= req_i.trigger;
      end else begin
        pins_o <= '0;
      end
    end
  end

  // Shared pin is released for the strap until configuration is loaded.
  always_comb begin
    pins_oe_o = (state == PBSP_ST_IDLE) || (state == PBSP_ST_RUN);
    buffer_index_msb_oe_o = pins_oe_o;
  end

  // Named steps of the port's life; the properties below are built from them.
  sequence seq_advance_taken;
    clk_en_i && state == PBSP_ST_RUN && req_i.advance;
  endsequence

  sequence seq_load_done;
    clk_en_i && state == PBSP_ST_LOAD && config_loaded_i;
  endsequence

  sequence seq_load_waiting;
    clk_en_i && state == PBSP_ST_LOAD && !config_loaded_i;
  endsequence

  sequence seq_run_dropped;
    clk_en_i && state == PBSP_ST_RUN && !buffer_ctrl_en_i;
  endsequence

  sequence seq_enable_written;
    clk_en_i && state == PBSP_ST_IDLE && buffer_ctrl_en_i;
  endsequence

  chk_strap_pin_input: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state == PBSP_ST_STRAP) |-> !buffer_index_msb_oe_o)
    else $error("strap pin driven during strap sampling");
  chk_idle_pins_low: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && state != PBSP_ST_RUN) |=> (pins_o == '0))
    else $error("outputs not low while disabled");
  chk_index_wraps: assert property (@(posedge core_clk_i) disable iff (srst_i)
    seq_advance_taken |=> (index == $past(index) + `PBSP_IDX_STEP))
    else $error("index did not step on advance");
  chk_advance_pin: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && state == PBSP_ST_RUN) |=> (pins_o.advance == $past(req_i.advance)))
    else $error("advance pin wrong");
  chk_index_pin: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && state == PBSP_ST_RUN && !req_i.advance) |=> (pins_o.index == index))
    else $error("index pin disagrees with index");
  chk_invert_pin: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && state == PBSP_ST_RUN) |=> (pins_o.invert == $past(req_i.invert)))
    else $error("invert pin wrong");
  chk_trigger_pin: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && state == PBSP_ST_RUN) |=> (pins_o.trigger == $past(req_i.trigger)))
    else $error("trigger pin wrong");
  chk_addr_choice: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state != PBSP_ST_STRAP) |->
    (target_addr_o == `PBSP_ADDR_STRAP_LOW || target_addr_o == `PBSP_ADDR_STRAP_HIGH))
    else $error("target address not a strap choice");
  chk_run_needs_en: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && state == PBSP_ST_IDLE && !buffer_ctrl_en_i) |=> (state == PBSP_ST_IDLE))
    else $error("function enabled without control write");

  // Life-cycle and strap checks that the pin checks above cannot see.
  chk_advance_index: assert property (@(posedge core_clk_i) disable iff (srst_i)
    seq_advance_taken |=> (pins_o.advance && pins_o.index == index))
    else $error("index pin not stepped with the strobe");
  chk_index_held: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state != PBSP_ST_RUN) |=> $stable(index))
    else $error("index moved while not running");
  chk_load_to_pins: assert property (@(posedge core_clk_i) disable iff (srst_i)
    seq_load_done |=> (pins_oe_o && pins_o == '0))
    else $error("pins not driven low after load");
  chk_load_waits: assert property (@(posedge core_clk_i) disable iff (srst_i)
    seq_load_waiting |=> (state == PBSP_ST_LOAD && !pins_oe_o))
    else $error("pins driven before load");
  chk_run_drop: assert property (@(posedge core_clk_i) disable iff (srst_i)
    seq_run_dropped |=> (state == PBSP_ST_IDLE))
    else $error("function kept after enable dropped");
  chk_enable_runs: assert property (@(posedge core_clk_i) disable iff (srst_i)
    seq_enable_written |=> (state == PBSP_ST_RUN))
    else $error("function not started after enable");
  chk_addr_held: assert property (@(posedge core_clk_i) disable iff (srst_i)
    addr_valid_o |=> (addr_valid_o && $stable(target_addr_o)))
    else $error("target address changed after capture");
  chk_strap_settled: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(addr_valid_o) |-> $past(strap_full && strap_steady))
    else $error("strap taken before synchroniser settled");
  chk_freeze_state: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !clk_en_i |=> ($stable(state) && $stable(index) && $stable(pins_o)))
    else $error("state moved while clock enable low");
  chk_strap_load_input: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state == PBSP_ST_LOAD) |-> !buffer_index_msb_oe_o)
    else $error("strap pin driven before load");
  chk_fill_stops: assert property (@(posedge core_clk_i) disable iff (srst_i)
    strap_full |=> strap_full)
    else $error("strap fill counter left full");
  chk_pins_no_oe: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !pins_oe_o |-> (pins_o == '0))
    else $error("pins carry values while released");
  chk_reset_values: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(srst_i) |-> (index == `PBSP_IDX_RESET && pins_o == '0 && !addr_valid_o))
    else $error("outputs not at reset values");
endmodule // pbsp_port

/* File: pbsp_fpga_model.sv */
// Companion FPGA side: strap resistor on the shared index pin.
`timescale 1ns/1ps
module pbsp_fpga_model (
  input wire logic strap_high_i,
  input wire logic msb_oe_i,
  input wire pbsp_pkg::pbsp_pins_t pins_i,
  output logic strap_pin_o
);
  import pbsp_pkg::*;
  // A released pin settles to the resistor level, not the last driven value.
  assign strap_pin_o = msb_oe_i ? pins_i.index[1] : strap_high_i;
endmodule // pbsp_fpga_model

/* File: pbsp_port_bench.sv */
// Self-checking bench for the pattern buffer signalling port.
`timescale 1ns/1ps
module pbsp_port_bench;
  import pbsp_pkg::*;
  `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
  logic core_clk_i = 0, srst_i = 1, cfg = 0, en = 0, hi = 0, ce = 1, msb_oe, oe, vld, pin;
  pbsp_req_t req = '0;
  pbsp_pins_t pins;
  logic [6:0] addr;
  int fail_count = 0, n_tests = 0;
  // Request bits beside expected pins; rows run back to back to hit the wrap.
  logic [7:0] rows [7] = '{8'h90, 8'h46, 8'h4a, 8'h6f, 8'hd2, 8'h21, 8'h00};
  always #25 core_clk_i = ~core_clk_i;
  pbsp_port i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .clk_en_i(ce),
    .config_loaded_i(cfg), .buffer_ctrl_en_i(en), .req_i(req),
    .addr_strap_pin_i(pin), .pins_o(pins), .buffer_index_msb_oe_o(msb_oe),
    .pins_oe_o(oe), .target_addr_o(addr), .addr_valid_o(vld));
  pbsp_fpga_model i_fpga (.strap_high_i(hi), .msb_oe_i(msb_oe), .pins_i(pins),
    .strap_pin_o(pin));
  task automatic stop_test;
    $display("Checks %0d, errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #5;
  endtask
  task automatic boot(input logic h);
    hi = h;
    srst_i = 1;
    cfg = 0;
    en = 0;
    cyc(10);
    `CHK({vld, oe, msb_oe, pins}, 8'h00)
    srst_i = 0;
    cyc(8);
    `CHK(addr, h ? 7'h1d : 7'h1b)
    `CHK(vld, 1'b1)
    `CHK(msb_oe, 1'b0)
    `CHK(oe, 1'b0)
    cfg = 1;
    cyc(2);
    `CHK({oe, msb_oe, pins}, 7'h60)
    en = 1;
    cyc(2);
  endtask
  initial begin
    boot(1'b0);
    foreach (rows[i]) begin
      req = pbsp_req_t'(rows[i][7:5]);
      cyc(1);
      `CHK(pins, rows[i][4:0])
    end
    // The enable drop takes one edge; a request after it is dropped and the index kept.
    en = 0;
    cyc(1);
    req = 3'h2;
    cyc(1);
    req = 3'h0;
    cyc(1);
    `CHK(pins, 5'h00)
    en = 1;
    cyc(2);
    req = 3'h2;
    cyc(1);
    `CHK(pins, 5'h06)
    // A low clock enable must hold the pins and the index despite a pending advance.
    ce = 0;
    cyc(2);
    `CHK(pins, 5'h06)
    req = 3'h0;
    ce = 1;
    cyc(1);
    `CHK(pins, 5'h04)
    boot(1'b1);
    stop_test();
  end
  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
endmodule // pbsp_port_bench
